/* File: verilog/tsd_defs.vh */
// register numbers, field positions, reset values and cause codes of the tile status bank
`ifndef TSD_DEFS_VH
`define TSD_DEFS_VH

`define TSD_REG_BOOT_STATUS     8'h03
`define TSD_REG_SECURITY        8'h05
`define TSD_REG_RO_CTRL         8'h06
`define TSD_REG_CNT_TILE_CELL   8'h07
`define TSD_REG_CNT_TILE_WIRE   8'h08
`define TSD_REG_CNT_PER_CELL    8'h09
`define TSD_REG_CNT_PER_WIRE    8'h0a
`define TSD_REG_DBG_STATUS      8'h10
`define TSD_REG_DBG_PC          8'h11
`define TSD_REG_DBG_SP          8'h12
`define TSD_REG_GETREG_CORE     8'h13
`define TSD_REG_GETREG_REG      8'h14
`define TSD_REG_IRQ_CAUSE       8'h15

`define TSD_BOOT_TILE_HI        23
`define TSD_BOOT_TILE_LO        16
`define TSD_BOOT_OTP_BIT        8
`define TSD_BOOT_MODE_HI        7
`define TSD_BOOT_MODE_LO        0
`define TSD_BOOT_SETTLE         3'h4

`define TSD_RO_TILE_EN_BIT      1
`define TSD_RO_PER_EN_BIT       0
`define TSD_RO_CTRL_RESET       2'b00
`define TSD_CNT_WIDTH           16

`define TSD_CORE_SEL_W          8
`define TSD_REG_SEL_W           5

`define TSD_CAUSE_UNIT_HI       17
`define TSD_CAUSE_UNIT_LO       16
`define TSD_CAUSE_CORE_HI       15
`define TSD_CAUSE_CORE_LO       8
`define TSD_CAUSE_TYPE_HI       2
`define TSD_CAUSE_TYPE_LO       0

`define TSD_CAUSE_NONE          3'h0
`define TSD_CAUSE_HOST          3'h1
`define TSD_CAUSE_DEBUG_CALL_INSTRUCTION         3'h2
`define TSD_CAUSE_IBRK          3'h3
`define TSD_CAUSE_DWATCH        3'h4
`define TSD_CAUSE_RWATCH        3'h5

`endif

/* File: verilog/tsd_ring_counter.v */
// one ring oscillator and the counter it clocks
`timescale 1ns/1ps
module tsd_ring_counter #(
    parameter WIDTH = 16
) (
    // oscillator clock and run control
    input  wire             i_ring_clk,
    input  wire             i_run,
    // counter value, in the oscillator's own domain
    output wire [WIDTH-1:0] o_count
);

    reg [WIDTH-1:0] count_r    = {WIDTH{1'b0}};
    reg [2:0]       run_sync_r = 3'h0;
    reg             run_r      = 1'b0;

    // run control comes from the tile clock: three stages, taken once two and three agree
    always @(posedge i_ring_clk) begin
        run_sync_r <= {run_sync_r[1:0], i_run};
        if (run_sync_r[1] == run_sync_r[2]) begin
            run_r <= run_sync_r[2];
        end
    end

    // no reset: the count survives a system reset, counts up while running and wraps;
    // the declared start value stands for power-up only
    always @(posedge i_ring_clk) begin
        if (run_r) begin
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign o_count = count_r;

endmodule // tsd_ring_counter

/* File: verilog/tsd_sync3.v */
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module tsd_sync3 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_rstn,
    // raw input and filtered result
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    reg [WIDTH-1:0] out_r;

    // shift chain, then accept a new value only where stages agree
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r  <= {WIDTH{1'b0}};
            s2_r  <= {WIDTH{1'b0}};
            s3_r  <= {WIDTH{1'b0}};
            out_r <= {WIDTH{1'b0}};
        end else begin
            s1_r  <= i_async;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= (s2_r & s3_r) | (out_r & (s2_r | s3_r));
        end
    end

    assign o_sync = out_r;

endmodule // tsd_sync3

/* File: verilog/tsd_status_regs.v */
// processor status register bank: boot status, security copy, ring oscillators, debug
//
// How it works
// - boot status bits 23:16 read the tile number on the switch
// - boot status bit 8 reads one when boot from one-time memory is enabled
// - boot status bits 7:0 show the sampled boot mode pins
// - security register reads the security word copied from one-time memory
// - four ring oscillators each clock a counter, started and stopped by control
// - control bit 1 runs tile oscillators, bit 0 peripheral ones; reset stops both
// - oscillators run apart from the tile clock, usable for random bits
// - each counter reads in bits 15:0, upper bits zero
// - system reset leaves counter values alone
// - registers 0x07 to 0x0a: tile cell, tile wire, peripheral cell, peripheral wire
// - debugger entry captures the saved status into register 0x10
// - debugger entry captures saved program counter into 0x11, debugger may write it
// - debugger entry captures saved stack pointer into 0x12, debugger may write it
// - get-register core select holds the core number in bits 7:0
// - get-register register select holds the register number in bits 4:0
// - cause bits 2:0 record why debug was entered, reset to zero
// - hardware trigger cause records lowest firing unit index in bits 17:16
// - bits 15:8 hold the raising core's number, otherwise zero
// - processor reaches registers by numbered status reads and writes
`timescale 1ns/1ps
`include "tsd_defs.vh"
module tsd_status_regs #(
    parameter UNITS = 4
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rstn,
    // processor status access, numbered registers
    input  wire        i_ps_rd,
    input  wire        i_ps_wr,
    input  wire [7:0]  i_ps_num,
    input  wire [31:0] i_ps_wdata,
    input  wire        i_ps_debug,
    output wire [31:0] o_ps_rdata,
    output wire        o_ps_rvalid,
    // boot straps and one-time memory contents
    input  wire [7:0]  i_tile_number,
    input  wire        i_otp_boot_en,
    input  wire        i_boot_mode_pins,
    input  wire [7:0]  i_boot_mode_pin_bus,
    input  wire [31:0] i_security_word,
    // ring oscillator clocks
    input  wire        i_ring_tile_cell_clk,
    input  wire        i_ring_tile_wire_clk,
    input  wire        i_ring_per_cell_clk,
    input  wire        i_ring_per_wire_clk,
    // debugger entry and cause
    input  wire        i_dbg_entry,
    input  wire [31:0] i_saved_status_reg,
    input  wire [31:0] i_saved_program_counter,
    input  wire [31:0] i_saved_stack_pointer,
    input  wire [2:0]  i_dbg_cause,
    input  wire [UNITS-1:0] i_dbg_units_fired,
    input  wire        i_dbg_core_valid,
    input  wire [7:0]  i_dbg_core_num,
    // ring oscillator run enables and debug state to the core
    output wire        o_ring_tile_run,
    output wire        o_ring_per_run,
    output wire [31:0] o_saved_program_counter,
    output wire [31:0] o_saved_stack_pointer,
    output wire [7:0]  o_getreg_core_sel,
    output wire [4:0]  o_getreg_reg_sel
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // index of the lowest set bit of the fired-unit vector;
    // scanning downwards leaves the lowest firing unit as the last one taken
    function [1:0] lowest_unit;
        input [UNITS-1:0] v;
        integer k;
        begin
            lowest_unit = 2'd0;
            for (k = UNITS-1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    lowest_unit = k[1:0];
                end
            end
        end
    endfunction

    // cause is a hardware breakpoint or watchpoint
    function is_hw_cause;
        input [2:0] c;
        begin
            is_hw_cause = (c == `TSD_CAUSE_IBRK) || (c == `TSD_CAUSE_DWATCH) ||
                          (c == `TSD_CAUSE_RWATCH);
        end
    endfunction

    // a status write aimed at one register number; debug registers also need debug mode
    function write_hit;
        input       wr;
        input       dbg;
        input [7:0] num;
        input [7:0] want;
        input       need_dbg;
        begin
            write_hit = wr && (num == want) && (dbg || !need_dbg);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // boot strap sampling

    wire [7:0] mode_sync;
    reg  [7:0] boot_mode_r;
    reg        otp_boot_r;
    reg  [7:0] tile_num_r;
    reg [31:0] security_r;
    reg        boot_seen_r;
    reg  [2:0] settle_r;
    wire       mode_ready = (settle_r == `TSD_BOOT_SETTLE);

    // mode pins come from outside the clock domain
    tsd_sync3 #(
        .WIDTH (8)
    ) u_mode_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async (i_boot_mode_pin_bus),
        .o_sync  (mode_sync)
    );

    // the mode pins need a few edges after reset to pass the synchroniser;
    // capturing earlier would latch the synchroniser's reset value instead
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            settle_r <= 3'h0;
        end else if (!mode_ready) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    // tile number, boot enable and security word follow their inputs; mode pins are captured once, then held
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_mode_r <= 8'h00;
            otp_boot_r  <= 1'b0;
            tile_num_r  <= 8'h00;
            security_r  <= 32'h0000_0000;
            boot_seen_r <= 1'b0;
        end else begin
            tile_num_r <= i_tile_number;
            otp_boot_r <= i_otp_boot_en;
            security_r <= i_security_word;
            if (i_boot_mode_pins && mode_ready && !boot_seen_r) begin
                boot_mode_r <= mode_sync;
                boot_seen_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ring oscillators

    reg  [1:0]  ro_ctrl_r;
    wire [15:0] cnt_tc;
    wire [15:0] cnt_tw;
    wire [15:0] cnt_pc;
    wire [15:0] cnt_pw;

    // counters run in the oscillator domains; reads are only trusted when stopped,
    // since a count read while its oscillator runs may be caught mid-carry
    tsd_ring_counter #(.WIDTH(`TSD_CNT_WIDTH)) u_ro_tc (
        .i_ring_clk (i_ring_tile_cell_clk),
        .i_run      (ro_ctrl_r[`TSD_RO_TILE_EN_BIT]),
        .o_count    (cnt_tc)
    );
    tsd_ring_counter #(.WIDTH(`TSD_CNT_WIDTH)) u_ro_tw (
        .i_ring_clk (i_ring_tile_wire_clk),
        .i_run      (ro_ctrl_r[`TSD_RO_TILE_EN_BIT]),
        .o_count    (cnt_tw)
    );
    tsd_ring_counter #(.WIDTH(`TSD_CNT_WIDTH)) u_ro_pc (
        .i_ring_clk (i_ring_per_cell_clk),
        .i_run      (ro_ctrl_r[`TSD_RO_PER_EN_BIT]),
        .o_count    (cnt_pc)
    );
    tsd_ring_counter #(.WIDTH(`TSD_CNT_WIDTH)) u_ro_pw (
        .i_ring_clk (i_ring_per_wire_clk),
        .i_run      (ro_ctrl_r[`TSD_RO_PER_EN_BIT]),
        .o_count    (cnt_pw)
    );

    ////////////////////////////////////////////////////////////////////////////
    // debug registers

    reg [31:0] dbg_status_r;
    reg [31:0] dbg_pc_r;
    reg [31:0] dbg_sp_r;
    reg [7:0]  core_sel_r;
    reg [4:0]  reg_sel_r;
    reg [2:0]  cause_type_r;
    reg [1:0]  cause_unit_r;
    reg [7:0]  cause_core_r;
    reg [1:0]  cause_unit_nxt;
    reg [7:0]  cause_core_nxt;

    // run control is open to any write; the rest only to debug-mode writes
    wire wr_hit_pc    = write_hit(i_ps_wr, i_ps_debug, i_ps_num, `TSD_REG_DBG_PC, 1'b1);
    wire wr_hit_sp    = write_hit(i_ps_wr, i_ps_debug, i_ps_num, `TSD_REG_DBG_SP, 1'b1);
    wire wr_hit_core  = write_hit(i_ps_wr, i_ps_debug, i_ps_num, `TSD_REG_GETREG_CORE, 1'b1);
    wire wr_hit_reg   = write_hit(i_ps_wr, i_ps_debug, i_ps_num, `TSD_REG_GETREG_REG, 1'b1);
    wire wr_hit_cause = write_hit(i_ps_wr, i_ps_debug, i_ps_num, `TSD_REG_IRQ_CAUSE, 1'b1);
    wire wr_hit_ctrl  = write_hit(i_ps_wr, i_ps_debug, i_ps_num, `TSD_REG_RO_CTRL, 1'b0);

    // cause fields as seen at entry: unit index only for a hardware trigger,
    // core number only when a logical core raised the interrupt
    always @* begin
        cause_unit_nxt = 2'h0;
        cause_core_nxt = 8'h00;
        if (is_hw_cause(i_dbg_cause)) begin
            cause_unit_nxt = lowest_unit(i_dbg_units_fired);
        end
        if (i_dbg_core_valid) begin
            cause_core_nxt = i_dbg_core_num;
        end
    end

    // software-only registers: run control and the get-register operands
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ro_ctrl_r  <= `TSD_RO_CTRL_RESET;
            core_sel_r <= 8'h00;
            reg_sel_r  <= 5'h00;
        end else begin
            if (wr_hit_ctrl) begin
                ro_ctrl_r <= i_ps_wdata[1:0];
            end
            if (wr_hit_core) begin
                core_sel_r <= i_ps_wdata[7:0];
            end
            if (wr_hit_reg) begin
                reg_sel_r <= i_ps_wdata[4:0];
            end
        end
    end

    // debugger entry capture takes precedence over a same-cycle debug write,
    // so the debugger always sees the state of the moment it was called
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dbg_status_r <= 32'h0000_0000;
            dbg_pc_r     <= 32'h0000_0000;
            dbg_sp_r     <= 32'h0000_0000;
            cause_type_r <= `TSD_CAUSE_NONE;
            cause_unit_r <= 2'h0;
            cause_core_r <= 8'h00;
        end else begin
            if (i_dbg_entry) begin
                dbg_status_r <= i_saved_status_reg;
                dbg_pc_r     <= i_saved_program_counter;
                dbg_sp_r     <= i_saved_stack_pointer;
                cause_type_r <= i_dbg_cause;
                cause_unit_r <= cause_unit_nxt;
                cause_core_r <= cause_core_nxt;
            end else begin
                if (wr_hit_pc) begin
                    dbg_pc_r <= i_ps_wdata;
                end
                if (wr_hit_sp) begin
                    dbg_sp_r <= i_ps_wdata;
                end
                if (wr_hit_cause) begin
                    cause_type_r <= i_ps_wdata[2:0];
                    cause_unit_r <= i_ps_wdata[17:16];
                    cause_core_r <= i_ps_wdata[15:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    reg [31:0] rd_mux;
    reg [31:0] rdata_r;
    reg        rvalid_r;

    // numbered read decode; unknown or reserved reads as zero,
    // so an unlisted number never returns stale data
    always @* begin
        rd_mux = 32'h0000_0000;
        case (i_ps_num)
            `TSD_REG_BOOT_STATUS: begin
                rd_mux[`TSD_BOOT_TILE_HI:`TSD_BOOT_TILE_LO] = tile_num_r;
                rd_mux[`TSD_BOOT_OTP_BIT]                   = otp_boot_r;
                rd_mux[`TSD_BOOT_MODE_HI:`TSD_BOOT_MODE_LO] = boot_mode_r;
            end
            `TSD_REG_SECURITY:      rd_mux = security_r;
            `TSD_REG_RO_CTRL:       rd_mux[1:0] = ro_ctrl_r;
            `TSD_REG_CNT_TILE_CELL: rd_mux[15:0] = cnt_tc;
            `TSD_REG_CNT_TILE_WIRE: rd_mux[15:0] = cnt_tw;
            `TSD_REG_CNT_PER_CELL:  rd_mux[15:0] = cnt_pc;
            `TSD_REG_CNT_PER_WIRE:  rd_mux[15:0] = cnt_pw;
            `TSD_REG_DBG_STATUS:    rd_mux = dbg_status_r;
            `TSD_REG_DBG_PC:        rd_mux = dbg_pc_r;
            `TSD_REG_DBG_SP:        rd_mux = dbg_sp_r;
            `TSD_REG_GETREG_CORE:   rd_mux[7:0] = core_sel_r;
            `TSD_REG_GETREG_REG:    rd_mux[4:0] = reg_sel_r;
            `TSD_REG_IRQ_CAUSE: begin
                rd_mux[`TSD_CAUSE_UNIT_HI:`TSD_CAUSE_UNIT_LO] = cause_unit_r;
                rd_mux[`TSD_CAUSE_CORE_HI:`TSD_CAUSE_CORE_LO] = cause_core_r;
                rd_mux[`TSD_CAUSE_TYPE_HI:`TSD_CAUSE_TYPE_LO] = cause_type_r;
            end
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    // registered read answer, one cycle after the request;
    // the data then stands until the next read
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_ps_rd;
            if (i_ps_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every output is a straight copy of a flip-flop
    assign o_ps_rdata              = rdata_r;
    assign o_ps_rvalid             = rvalid_r;
    assign o_ring_tile_run         = ro_ctrl_r[`TSD_RO_TILE_EN_BIT];
    assign o_ring_per_run          = ro_ctrl_r[`TSD_RO_PER_EN_BIT];
    assign o_saved_program_counter = dbg_pc_r;
    assign o_saved_stack_pointer   = dbg_sp_r;
    assign o_getreg_core_sel       = core_sel_r;
    assign o_getreg_reg_sel        = reg_sel_r;

endmodule // tsd_status_regs

/* File: test/tsd_status_monitor.sv */
// port assertions for the tile status register bank
`timescale 1ns/1ps
module tsd_status_monitor #(
    parameter UNITS = 4
) (
    // clock and reset
    input wire        i_clk,
    input wire        i_rstn,
    // status access and debug entry
    input wire        i_ps_rd,
    input wire        i_ps_wr,
    input wire [7:0]  i_ps_num,
    input wire [31:0] i_ps_wdata,
    input wire        i_ps_debug,
    input wire        i_dbg_entry,
    input wire [31:0] i_saved_program_counter,
    input wire [31:0] i_saved_stack_pointer,
    // bank outputs
    input wire [31:0] o_ps_rdata,
    input wire        o_ps_rvalid,
    input wire        o_ring_tile_run,
    input wire        o_ring_per_run,
    input wire [31:0] o_saved_program_counter,
    input wire [31:0] o_saved_stack_pointer,
    input wire [7:0]  o_getreg_core_sel,
    input wire [4:0]  o_getreg_reg_sel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // qualified debug-mode write that no debugger entry overrides
    wire dw = i_ps_wr && i_ps_debug && !i_dbg_entry;
    wire ctl_wr = i_ps_wr && i_ps_num == 8'h06;
    AST_RVALID: assert property (i_ps_rd |=> o_ps_rvalid)
        else $error("read not answered next cycle");
    AST_RVALID_PULSE: assert property (!i_ps_rd |=> !o_ps_rvalid)
        else $error("answer without a read");
    AST_BOOT_RSVD: assert property (i_ps_rd && i_ps_num == 8'h03
        |=> o_ps_rdata[31:24] == 8'h00 && o_ps_rdata[15:9] == 7'h00)
        else $error("boot status reserved bits set");
    AST_CTRL_READ: assert property (i_ps_rd && !i_ps_wr && i_ps_num == 8'h06
        |=> o_ps_rdata == {30'h0, o_ring_tile_run, o_ring_per_run})
        else $error("control read differs from run outputs");
    AST_CNT_RSVD: assert property (i_ps_rd && i_ps_num >= 8'h07 && i_ps_num <= 8'h0a
        |=> o_ps_rdata[31:16] == 16'h0000)
        else $error("counter upper bits set");
    AST_CTRL_WR: assert property (ctl_wr |=> o_ring_tile_run == $past(i_ps_wdata[1])
        && o_ring_per_run == $past(i_ps_wdata[0]))
        else $error("run outputs do not follow control write");
    AST_RUN_HOLD: assert property (!ctl_wr |=> $stable({o_ring_tile_run, o_ring_per_run}))
        else $error("run outputs moved without a write");
    AST_CORE_SEL: assert property (dw && i_ps_num == 8'h13
        |=> o_getreg_core_sel == $past(i_ps_wdata[7:0]))
        else $error("core select not written");
    AST_REG_SEL: assert property (dw && i_ps_num == 8'h14
        |=> o_getreg_reg_sel == $past(i_ps_wdata[4:0]))
        else $error("register select not written");
    AST_ENTRY: assert property (i_dbg_entry
        |=> o_saved_program_counter == $past(i_saved_program_counter)
        && o_saved_stack_pointer == $past(i_saved_stack_pointer))
        else $error("entry did not capture pc and sp");
    AST_PC_GUARD: assert property (i_ps_wr && !i_ps_debug && !i_dbg_entry
        |=> $stable(o_saved_program_counter))
        else $error("saved pc changed by a non-debug write");
    AST_CAUSE_RSVD: assert property (i_ps_rd && i_ps_num == 8'h15
        |=> o_ps_rdata[31:18] == 14'h0 && o_ps_rdata[7:3] == 5'h0)
        else $error("cause reserved bits set");
endmodule // tsd_status_monitor

/* File: test/tsd_core_model.sv */
// processor core model issuing numbered status reads and writes
`timescale 1ns/1ps
module tsd_core_model (
    // clock and answer from the bank
    input  wire        i_clk,
    input  wire [31:0] i_rdata,
    input  wire        i_rvalid,
    // status access request
    output reg         o_rd,
    output reg         o_wr,
    output reg  [7:0]  o_num,
    output reg  [31:0] o_wdata,
    output reg         o_debug
);
    // idle request lines from time zero
    initial begin
        {o_rd, o_wr, o_num, o_wdata, o_debug} = 43'h0;
    end
    // one write, held across exactly one taking edge
    task automatic wr(input [7:0] n, input [31:0] d, input dbg);
        @(negedge i_clk);
        {o_wr, o_num, o_wdata, o_debug} = {1'b1, n, d, dbg};
        @(negedge i_clk);
        {o_wr, o_wdata, o_debug} = {1'b0, ~d, 1'b0};
    endtask
    // one read; the answer stands in the cycle after the taking edge
    task automatic rd(input [7:0] n, output [31:0] d, output ok);
        @(negedge i_clk);
        {o_rd, o_num} = {1'b1, n};
        @(negedge i_clk);
        o_rd = 1'b0;
        ok = i_rvalid;
        d = i_rdata;
    endtask
endmodule // tsd_core_model

/* File: test/test_tile_status_debug_regs.sv */
// self-checking bench for the tile status register bank
`timescale 1ns/1ps
module test_tile_status_debug_regs;
    reg         i_clk, i_rstn, otp, entry, cvalid, strap;
    reg  [7:0]  tile, mode_bus, cnum;
    reg  [31:0] sec, saved_status_reg, saved_program_counter, saved_stack_pointer, a[0:3], b[0:3];
    reg  [3:0]  rclk, units;
    reg  [2:0]  cause;
    wire        ps_rd, ps_wr, ps_dbg, rvalid, tile_run, per_run;
    wire [7:0]  ps_num, csel;
    wire [31:0] ps_wd, rdata, pc_o, sp_o;
    wire [4:0]  rsel;
    integer     fails, tests_run, i;

    tsd_core_model core (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_rd(ps_rd),
        .o_wr(ps_wr), .o_num(ps_num), .o_wdata(ps_wd), .o_debug(ps_dbg));
    tsd_status_regs dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ps_rd(ps_rd), .i_ps_wr(ps_wr),
        .i_ps_num(ps_num), .i_ps_wdata(ps_wd), .i_ps_debug(ps_dbg), .o_ps_rdata(rdata),
        .o_ps_rvalid(rvalid), .i_tile_number(tile), .i_otp_boot_en(otp),
        .i_boot_mode_pins(strap), .i_boot_mode_pin_bus(mode_bus), .i_security_word(sec),
        .i_ring_tile_cell_clk(rclk[0]), .i_ring_tile_wire_clk(rclk[1]),
        .i_ring_per_cell_clk(rclk[2]), .i_ring_per_wire_clk(rclk[3]), .i_dbg_entry(entry),
        .i_saved_status_reg(saved_status_reg), .i_saved_program_counter(saved_program_counter),
        .i_saved_stack_pointer(saved_stack_pointer), .i_dbg_cause(cause), .i_dbg_units_fired(units),
        .i_dbg_core_valid(cvalid), .i_dbg_core_num(cnum), .o_ring_tile_run(tile_run),
        .o_ring_per_run(per_run), .o_saved_program_counter(pc_o),
        .o_saved_stack_pointer(sp_o), .o_getreg_core_sel(csel), .o_getreg_reg_sel(rsel));

    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fails = fails + 1;
        end
    endtask
    task rdchk(input [7:0] n, input [31:0] e);
        reg [31:0] d;
        reg        ok;
        core.rd(n, d, ok);
        chk("read valid", 32'h1, {31'h0, ok});
        chk("read data", e, d);
    endtask
    task rst;
        @(negedge i_clk);
        i_rstn = 1'b0;
        repeat (4) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task t_boot;
        rdchk(8'h03, 32'h00a5_0100);
        strap = 1'b1;
        rdchk(8'h03, 32'h00a5_013c);
        mode_bus = 8'h81;
        otp = 1'b0;
        core.wr(8'h03, 32'hffff_ffff, 1'b1);
        rdchk(8'h03, 32'h00a5_003c);
        rdchk(8'h05, 32'hc0de_5a17);
        core.wr(8'h05, 32'h0000_0000, 1'b1);
        rdchk(8'h05, 32'hc0de_5a17);
        rdchk(8'h04, 32'h0000_0000);
    endtask
    task t_ctrl;
        rdchk(8'h06, 32'h0000_0000);
        core.wr(8'h06, 32'hffff_ffff, 1'b0);
        rdchk(8'h06, 32'h0000_0003);
        chk("run outputs", 32'h3, {30'h0, tile_run, per_run});
        core.wr(8'h06, 32'h0000_0000, 1'b0);
    endtask
    task t_debug;
        for (i = 1; i <= 5; i = i + 1) begin
            @(negedge i_clk);
            {entry, cause, units, cvalid, cnum} = {1'b1, i[2:0], 4'b1100, i != 5, 8'h30 + i[7:0]};
            {saved_status_reg, saved_program_counter, saved_stack_pointer} = {32'h1111_0000 + i, 32'h2222_0000 + i, 32'h3333_0000 + i};
            @(negedge i_clk);
            entry = 1'b0;
            rdchk(8'h15, {14'h0, i >= 3 ? 2'd2 : 2'd0, i != 5 ? cnum : 8'h00, 5'h0, i[2:0]});
            rdchk(8'h10, saved_status_reg);
            rdchk(8'h11, saved_program_counter);
            rdchk(8'h12, saved_stack_pointer);
        end
        core.wr(8'h11, 32'hdead_beef, 1'b0);
        rdchk(8'h11, saved_program_counter);
        core.wr(8'h11, 32'hdead_beef, 1'b1);
        rdchk(8'h11, 32'hdead_beef);
        chk("saved pc", 32'hdead_beef, pc_o);
        core.wr(8'h12, 32'h0bad_cafe, 1'b1);
        chk("saved sp", 32'h0bad_cafe, sp_o);
        core.wr(8'h10, 32'h0000_0000, 1'b1);
        rdchk(8'h10, saved_status_reg);
        core.wr(8'h13, 32'hffff_ffff, 1'b1);
        rdchk(8'h13, 32'h0000_00ff);
        core.wr(8'h14, 32'hffff_ffff, 1'b1);
        rdchk(8'h14, 32'h0000_001f);
        chk("selects", 32'h1fff, {19'h0, rsel, csel});
        core.wr(8'h15, 32'hffff_ffff, 1'b1);
        rdchk(8'h15, 32'h0003_ff07);
    endtask
    // free oscillator bursts, out of phase with the tile clock
    task pulses;
        repeat (40) begin
            #1.7 rclk = 4'hf;
            #1.7 rclk = 4'h0;
        end
    endtask
    task snap(input [3:0] moved);
        reg ok;
        for (i = 0; i < 4; i = i + 1) begin
            a[i] = b[i];
            core.rd(8'h07 + i[7:0], b[i], ok);
            if (moved !== 4'hx)
                chk("count moved", {31'h0, moved[i]}, {31'h0, a[i] !== b[i]});
        end
    endtask
    task run_burst(input [31:0] ctl);
        core.wr(8'h06, ctl, 1'b0);
        repeat (4) @(negedge i_clk);
        pulses;
        core.wr(8'h06, 32'h0000_0000, 1'b0);
        repeat (4) @(negedge i_clk);
        pulses;
    endtask
    task t_rings;
        snap(4'hx);
        pulses;
        snap(4'h0);
        run_burst(32'h0000_0002);
        snap(4'h3);
        run_burst(32'h0000_0001);
        snap(4'hc);
        rst;
        snap(4'h0);
    endtask
    // main sequence
    initial begin
        {i_rstn, otp, entry, cvalid, rclk, units, cause} = {2'b01, 2'b00, 11'h0};
        {tile, mode_bus, cnum, sec} = {8'ha5, 8'h3c, 8'h00, 32'hc0de_5a17};
        {saved_status_reg, saved_program_counter, saved_stack_pointer} = 96'h0;
        strap = 1'b0;
        fails = 0;
        tests_run = 0;
        rst;
        t_boot;
        t_ctrl;
        t_debug;
        t_rings;
        give_verdict;
    end
    // watchdog against a hung handshake
    initial begin
        #100000;
        fails = fails + 1;
        give_verdict;
    end
endmodule // test_tile_status_debug_regs

bind tsd_status_regs tsd_status_monitor #(.UNITS(UNITS)) mon (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_ps_rd(i_ps_rd), .i_ps_wr(i_ps_wr), .i_ps_num(i_ps_num),
    .i_ps_wdata(i_ps_wdata), .i_ps_debug(i_ps_debug), .i_dbg_entry(i_dbg_entry),
    .i_saved_program_counter(i_saved_program_counter),
    .i_saved_stack_pointer(i_saved_stack_pointer), .o_ps_rdata(o_ps_rdata),
    .o_ps_rvalid(o_ps_rvalid), .o_ring_tile_run(o_ring_tile_run),
    .o_ring_per_run(o_ring_per_run), .o_saved_program_counter(o_saved_program_counter),
    .o_saved_stack_pointer(o_saved_stack_pointer), .o_getreg_core_sel(o_getreg_core_sel),
    .o_getreg_reg_sel(o_getreg_reg_sel));
